// ### shared/ascx_pkg.sv
/*
 constants, types and state codes for the asynchronous serial channel block.
 assumes a 10 MHz system clock and a baud tick made outside at 16x the bit rate.
*/
// How it works
// - software may pick longer transmit stop time
// - missing stop level raises framing error flag
// - status shows receive available, transmit empty
// - interrupt request when a character transfer needed
// - acknowledge places 8-bit vector on data
// - block mode interrupts only on first character
// - block mode paces later characters by ready
// - transfer mode independent of line format
// - two channels, each own control and status
// - single-channel build via channel count parameter
// - low start bit, high stop, idle high
// - five to eight data bits, per direction
// - stop one, one-and-half, two; receiver checks one
// - optional even or odd parity per channel
package ascx_pkg;
   localparam int OVERSAMPLE = 16;
   localparam logic [4:0] TICK_LAST = 5'h0F;
   localparam logic [4:0] TICK_HALF = 5'h07;
   localparam logic [4:0] TICK_ONE_HALF = 5'h17;
   localparam logic [4:0] TICK_TWO = 5'h1F;
   localparam logic [3:0] LEN_BASE = 4'h5;
   localparam logic [1:0] STOP_ONE = 2'h0;
   localparam logic [1:0] STOP_ONE_HALF = 2'h1;
   localparam logic [1:0] STOP_TWO = 2'h2;
   localparam logic [1:0] MODE_POLL = 2'h0;
   localparam logic [1:0] MODE_IRQ = 2'h1;
   localparam logic [1:0] MODE_BLOCK = 2'h2;
   localparam int STAT_RX_AVAIL = 0;
   localparam int STAT_TX_EMPTY = 2;
   localparam int STAT_PARITY_ERR = 4;
   localparam int STAT_OVERRUN = 5;
   localparam int STAT_FRAME_ERR = 6;
   localparam logic [7:0] VECTOR_RESET = 8'h00;
   typedef enum logic [4:0]
   {
      ASCX_IDLE = 5'h01,
      ASCX_START = 5'h02,
      ASCX_DATA = 5'h04,
      ASCX_PAR = 5'h08,
      ASCX_STOP = 5'h10
   } ascx_state_e;
endpackage : ascx_pkg

// ### design/ascx_channel.sv
/*
 one full-duplex asynchronous channel: framer, deframer, status and per-channel requests.
 assumes i_tick pulses one clock per 1/16 bit time; i_rxd is already synchronous.
*/
`timescale 1ns/10ps
module ascx_channel
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_tick,
   input wire logic i_rxd,
   output logic o_txd,
   input wire logic [1:0] i_tx_len,
   input wire logic [1:0] i_rx_len,
   input wire logic [1:0] i_stop_sel,
   input wire logic i_par_en,
   input wire logic i_par_odd,
   input wire logic [1:0] i_mode,
   input wire logic i_tx_wr,
   input wire logic [7:0] i_tx_data,
   input wire logic i_rx_rd,
   input wire logic i_err_clr,
   output logic [7:0] o_rx_data,
   output logic [7:0] o_status,
   output logic o_irq,
   output logic o_ready
);
   typedef struct packed
   {
      ascx_pkg::ascx_state_e ts;
      logic [4:0] tt;
      logic [2:0] tb;
      logic [7:0] tsh;
      logic tpar;
      logic [7:0] thold;
      logic tfull;
      logic txd;
      ascx_pkg::ascx_state_e rs;
      logic [4:0] rt;
      logic [2:0] rb;
      logic [7:0] rsh;
      logic rpar;
      logic [7:0] rdat;
      logic ravail;
      logic perr;
      logic ovr;
      logic ferr;
      logic first;
      logic irq_rx;
   } ascx_chan_s;
   ascx_chan_s st;
   ascx_chan_s next_st;
   logic [2:0] tlast;
   logic [2:0] rlast;
   logic [4:0] stop_end;
   logic [7:0] rbyte;
   always_comb
   begin
      tlast = 3'(ascx_pkg::LEN_BASE - 4'h1) + 3'(i_tx_len);
      rlast = 3'(ascx_pkg::LEN_BASE - 4'h1) + 3'(i_rx_len);
      unique case (i_stop_sel)
         ascx_pkg::STOP_ONE_HALF: stop_end = ascx_pkg::TICK_ONE_HALF;
         ascx_pkg::STOP_TWO: stop_end = ascx_pkg::TICK_TWO;
         default: stop_end = ascx_pkg::TICK_LAST;
      endcase
      rbyte = st.rsh >> (3'h7 - st.rb);
      next_st = st;
      if (i_tx_wr && !st.tfull)
      begin
         next_st.thold = i_tx_data;
         next_st.tfull = 1'b1;
      end
      if (i_tick)
      begin
         next_st.tt = st.tt + 5'h01;
         unique case (st.ts)
            ascx_pkg::ASCX_IDLE:
            begin
               next_st.txd = 1'b1;
               next_st.tt = 5'h00;
               if (st.tfull)
               begin
                  next_st.ts = ascx_pkg::ASCX_START;
                  next_st.tsh = st.thold;
                  next_st.tfull = 1'b0;
                  next_st.tb = 3'h0;
                  next_st.tpar = i_par_odd;
                  next_st.txd = 1'b0;
               end
            end
            ascx_pkg::ASCX_START:
               if (st.tt == ascx_pkg::TICK_LAST)
               begin
                  next_st.ts = ascx_pkg::ASCX_DATA;
                  next_st.tt = 5'h00;
                  next_st.txd = st.tsh[0];
               end
            ascx_pkg::ASCX_DATA:
               if (st.tt == ascx_pkg::TICK_LAST)
               begin
                  next_st.tt = 5'h00;
                  next_st.tpar = st.tpar ^ st.tsh[0];
                  next_st.tsh = {1'b0, st.tsh[7:1]};
                  next_st.tb = st.tb + 3'h1;
                  next_st.txd = st.tsh[1];
                  if (st.tb == tlast)
                  begin
                     next_st.ts = i_par_en ? ascx_pkg::ASCX_PAR : ascx_pkg::ASCX_STOP;
                     next_st.txd = i_par_en ? (st.tpar ^ st.tsh[0]) : 1'b1;
                  end
               end
            ascx_pkg::ASCX_PAR:
               if (st.tt == ascx_pkg::TICK_LAST)
               begin
                  next_st.ts = ascx_pkg::ASCX_STOP;
                  next_st.tt = 5'h00;
                  next_st.txd = 1'b1;
               end
            ascx_pkg::ASCX_STOP:
               if (st.tt == stop_end)
               begin
                  next_st.ts = ascx_pkg::ASCX_IDLE;
                  next_st.tt = 5'h00;
               end
         endcase
      end
      if (i_rx_rd && st.ravail)
      begin
         next_st.ravail = 1'b0;
         next_st.irq_rx = 1'b0;
      end
      if (i_err_clr)
      begin
         next_st.perr = 1'b0;
         next_st.ovr = 1'b0;
         next_st.ferr = 1'b0;
      end
      if (i_mode != ascx_pkg::MODE_BLOCK)
         next_st.first = 1'b1;
      if (i_tick)
      begin
         next_st.rt = st.rt + 5'h01;
         unique case (st.rs)
            ascx_pkg::ASCX_IDLE:
            begin
               next_st.rt = 5'h00;
               if (!i_rxd)
                  next_st.rs = ascx_pkg::ASCX_START;
            end
            ascx_pkg::ASCX_START:
               if (st.rt == ascx_pkg::TICK_HALF)
               begin
                  next_st.rt = 5'h00;
                  next_st.rb = 3'h0;
                  next_st.rpar = i_par_odd;
                  next_st.rs = i_rxd ? ascx_pkg::ASCX_IDLE : ascx_pkg::ASCX_DATA; // glitch rejects
               end
            ascx_pkg::ASCX_DATA:
               if (st.rt == ascx_pkg::TICK_LAST)
               begin
                  next_st.rt = 5'h00;
                  next_st.rsh = {i_rxd, st.rsh[7:1]};
                  next_st.rpar = st.rpar ^ i_rxd;
                  next_st.rb = st.rb + 3'h1;
                  if (st.rb == rlast)
                  begin
                     next_st.rb = st.rb;
                     next_st.rs = i_par_en ? ascx_pkg::ASCX_PAR : ascx_pkg::ASCX_STOP;
                  end
               end
            ascx_pkg::ASCX_PAR:
               if (st.rt == ascx_pkg::TICK_LAST)
               begin
                  next_st.rt = 5'h00;
                  next_st.rs = ascx_pkg::ASCX_STOP;
                  if (st.rpar ^ i_rxd)
                     next_st.perr = 1'b1;
               end
            ascx_pkg::ASCX_STOP:
               if (st.rt == ascx_pkg::TICK_LAST)
               begin
                  next_st.rs = ascx_pkg::ASCX_IDLE;
                  next_st.rt = 5'h00;
                  if (!i_rxd)
                     next_st.ferr = 1'b1;
                  if (st.ravail)
                     next_st.ovr = 1'b1;
                  next_st.rdat = rbyte;
                  next_st.ravail = 1'b1; // set wins over read
                  // only the first character of a block raises the request
                  next_st.irq_rx = (i_mode == ascx_pkg::MODE_IRQ) ||
                     (i_mode == ascx_pkg::MODE_BLOCK && st.first);
                  next_st.first = 1'b0;
               end
         endcase
      end
      if (!i_rst_n)
      begin
         next_st = '0;
         next_st.ts = ascx_pkg::ASCX_IDLE;
         next_st.rs = ascx_pkg::ASCX_IDLE;
         next_st.txd = 1'b1;
         next_st.first = 1'b1;
      end
   end
   always_ff @(posedge i_clk)
   begin
      st <= next_st;
   end
   assign o_txd = st.txd;
   assign o_rx_data = st.rdat;
   always_comb
   begin
      o_status = 8'h00;
      o_status[ascx_pkg::STAT_RX_AVAIL] = st.ravail;
      o_status[ascx_pkg::STAT_TX_EMPTY] = !st.tfull;
      o_status[ascx_pkg::STAT_PARITY_ERR] = st.perr;
      o_status[ascx_pkg::STAT_OVERRUN] = st.ovr;
      o_status[ascx_pkg::STAT_FRAME_ERR] = st.ferr;
   end
   // mode only gates requests, never line format
   // a receive request left over from another mode stays hidden while polled
   assign o_irq = (st.irq_rx && i_mode != ascx_pkg::MODE_POLL) ||
      (i_mode == ascx_pkg::MODE_IRQ && !st.tfull);
   assign o_ready = (i_mode == ascx_pkg::MODE_BLOCK) && !st.first && st.ravail;
endmodule : ascx_channel

// ### design/ascx_top.sv
/*
 top of the asynchronous serial channel block: channel array, interrupt vector, acknowledge.
 assumes the host drives per-channel strobes as single-cycle pulses synchronous to i_clk.
*/
`timescale 1ns/10ps
module ascx_top
#(
   parameter int CHANNELS = 2
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [CHANNELS-1:0] i_tick,
   input wire logic [CHANNELS-1:0] i_rxd,
   output logic [CHANNELS-1:0] o_txd,
   input wire logic [2*CHANNELS-1:0] i_tx_len,
   input wire logic [2*CHANNELS-1:0] i_rx_len,
   input wire logic [2*CHANNELS-1:0] i_stop_sel,
   input wire logic [CHANNELS-1:0] i_par_en,
   input wire logic [CHANNELS-1:0] i_par_odd,
   input wire logic [2*CHANNELS-1:0] i_mode,
   input wire logic [CHANNELS-1:0] i_tx_wr,
   input wire logic [8*CHANNELS-1:0] i_tx_data,
   input wire logic [CHANNELS-1:0] i_rx_rd,
   input wire logic [CHANNELS-1:0] i_err_clr,
   output logic [8*CHANNELS-1:0] o_rx_data,
   output logic [8*CHANNELS-1:0] o_status,
   output logic [CHANNELS-1:0] o_ready,
   input wire logic i_vec_wr,
   input wire logic [7:0] i_vec_data,
   input wire logic i_int_ack,
   output logic o_int_req,
   output logic [7:0] o_vector
);
   // ************************
   // channels
   // ************************
   logic [CHANNELS-1:0] irq;
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : g_ch
         ascx_channel u_ch
         (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_tick(i_tick[g]),
            .i_rxd(i_rxd[g]),
            .o_txd(o_txd[g]),
            .i_tx_len(i_tx_len[2*g +: 2]),
            .i_rx_len(i_rx_len[2*g +: 2]),
            .i_stop_sel(i_stop_sel[2*g +: 2]),
            .i_par_en(i_par_en[g]),
            .i_par_odd(i_par_odd[g]),
            .i_mode(i_mode[2*g +: 2]),
            .i_tx_wr(i_tx_wr[g]),
            .i_tx_data(i_tx_data[8*g +: 8]),
            .i_rx_rd(i_rx_rd[g]),
            .i_err_clr(i_err_clr[g]),
            .o_rx_data(o_rx_data[8*g +: 8]),
            .o_status(o_status[8*g +: 8]),
            .o_irq(irq[g]),
            .o_ready(o_ready[g])
         );
      end
   endgenerate
   // ************************
   // vector
   // ************************
   typedef struct packed
   {
      logic [7:0] base;
      logic [7:0] vec;
   } ascx_top_s;
   ascx_top_s st;
   ascx_top_s next_st;
   logic [2:0] src;
   always_comb
   begin
      src = 3'h0;
      for (int i = CHANNELS - 1; i >= 0; i--)
         if (irq[i])
            src = 3'(i); // lowest channel wins
      next_st = st;
      if (i_vec_wr)
         next_st.base = i_vec_data;
      if (i_int_ack)
         next_st.vec = {st.base[7:3], src};
      if (!i_rst_n)
      begin
         next_st.base = ascx_pkg::VECTOR_RESET;
         next_st.vec = ascx_pkg::VECTOR_RESET;
      end
   end
   always_ff @(posedge i_clk)
   begin
      st <= next_st;
   end
   assign o_int_req = |irq;
   assign o_vector = st.vec;
endmodule : ascx_top

// ### tb/ascx_asserts.sv
/*
 checker for the serial channel top: status, vector and request timing.
 assumes it is bound onto ascx_top and sees its ports only.
*/
`timescale 1ns/10ps
module ascx_asserts
#(
   parameter int CHANNELS = 2
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [CHANNELS-1:0] o_txd,
   input wire logic [2*CHANNELS-1:0] i_mode,
   input wire logic [CHANNELS-1:0] i_tx_wr,
   input wire logic [CHANNELS-1:0] i_rx_rd,
   input wire logic [CHANNELS-1:0] i_err_clr,
   input wire logic [8*CHANNELS-1:0] o_status,
   input wire logic [CHANNELS-1:0] o_ready,
   input wire logic i_vec_wr,
   input wire logic [7:0] i_vec_data,
   input wire logic i_int_ack,
   input wire logic o_int_req,
   input wire logic [7:0] o_vector
);
   // ****************
   // helpers
   // ****************
   logic [4:0] base;
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         base <= 5'h00;
      else if (i_vec_wr)
         base <= i_vec_data[7:3];
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence wr_taken;
      i_tx_wr[0] && o_status[2];
   endsequence
   // ****************
   // properties
   // ****************
   reset_values_a: assert property (disable iff (1'b0) !i_rst_n |=> o_txd == '1 && o_status[7:0] == 8'h04) else $error("reset values wrong");
   tx_load_a: assert property (wr_taken |=> !o_status[2]) else $error("holding empty after write");
   vec_load_a: assert property (i_int_ack && !i_vec_wr |=> o_vector[7:3] == $past(base)) else $error("vector base wrong");
   vec_hold_a: assert property (!i_int_ack |=> $stable(o_vector)) else $error("vector moved without ack");
   poll_quiet_a: assert property ((i_mode == '0) [*3] |-> !o_int_req) else $error("request in polled mode");
   ready_block_a: assert property (o_ready[0] |-> i_mode[1:0] == ascx_pkg::MODE_BLOCK) else $error("ready outside block");
   rx_hold_a: assert property (o_status[0] && !i_rx_rd[0] |=> o_status[0]) else $error("receive flag dropped");
   ferr_hold_a: assert property (o_status[6] && !i_err_clr[0] |=> o_status[6]) else $error("framing flag dropped");
endmodule : ascx_asserts
bind ascx_top ascx_asserts #(.CHANNELS(CHANNELS)) asserts_u (.i_clk, .i_rst_n, .o_txd, .i_mode, .i_tx_wr, .i_rx_rd,
   .i_err_clr, .o_status, .o_ready, .i_vec_wr, .i_vec_data, .i_int_ack, .o_int_req, .o_vector);

// ### tb/ascx_far_end.sv
/*
 remote serial sender on the line side of channel 0.
 assumes i_tick is the same 16x tick the channel sees.
*/
`timescale 1ns/10ps
module ascx_far_end
(
   input wire logic i_clk,
   input wire logic i_tick,
   input wire logic i_go,
   input wire logic [7:0] i_char,
   input wire logic [3:0] i_bits,
   input wire logic i_bad_stop,
   output logic o_line
);
   logic [10:0] frame = 11'h7FF;
   logic [10:0] load;
   logic [3:0] left = 4'h0;
   logic [3:0] sub = 4'h0;
   // frame built apart, so the line only moves by non-blocking update
   always_comb
   begin
      load = 11'h7FE;
      for (int i = 0; i < 8; i++)
         if (i < i_bits)
            load[i + 1] = i_char[i];
      load[i_bits + 1] = !i_bad_stop;
   end
   always @(posedge i_clk)
   begin
      if (i_go)
      begin
         frame <= load;
         left <= i_bits + 4'h2;
         sub <= 4'h0;
      end
      else if (i_tick && left != 4'h0)
      begin
         sub <= sub + 4'h1;
         if (sub == 4'hF)
         begin
            frame <= {1'b1, frame[10:1]};
            left <= left - 4'h1;
         end
      end
   end
   // released line rests at mark level
   assign o_line = (left != 4'h0) ? frame[0] : 1'b1;
endmodule : ascx_far_end

// ### tb/testbench.sv
/*
 self-checking bench for ascx_top: far-end sender on channel 0, loopback 0 to 1.
 assumes two channels and a tick every second clock.
*/
`timescale 1ns/10ps
module testbench;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_vec_wr = 1'b0, i_int_ack = 1'b0, go = 1'b0, bad = 1'b0, line, o_int_req;
   logic [1:0] i_tick = 2'h0, i_par_en = 2'h0, i_par_odd = 2'h0, i_tx_wr = 2'h0, i_rx_rd = 2'h0, i_err_clr = 2'h0;
   logic [3:0] i_tx_len = 4'hF, i_rx_len = 4'hF, i_stop_sel = 4'h0, i_mode = 4'h0, nb = 4'h8;
   logic [7:0] i_vec_data = 8'h00, pc = 8'h00, o_vector;
   logic [15:0] i_tx_data = 16'h0000, o_rx_data, o_status;
   logic [1:0] o_txd, o_ready;
   wire logic [1:0] i_rxd = {o_txd[0], line};
   int bad_count = 0, n_compared = 0;
   ascx_top dut_u (.i_clk, .i_rst_n, .i_tick, .i_rxd, .o_txd, .i_tx_len, .i_rx_len, .i_stop_sel, .i_par_en,
      .i_par_odd, .i_mode, .i_tx_wr, .i_tx_data, .i_rx_rd, .i_err_clr, .o_rx_data, .o_status, .o_ready, .i_vec_wr,
      .i_vec_data, .i_int_ack, .o_int_req, .o_vector);
   ascx_far_end far_u (.i_clk, .i_tick(i_tick[0]), .i_go(go), .i_char(pc), .i_bits(nb), .i_bad_stop(bad),
      .o_line(line));
   // ****************
   // helpers
   // ****************
   initial
   begin
      forever #50 i_clk = ~i_clk;
   end
   always @(posedge i_clk) i_tick <= ~i_tick;
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task step(input int n);
      repeat (n) @(negedge i_clk);
   endtask : step
   // one-cycle strobe; all strobes drop together
   task strobe(input int w, input logic [1:0] v);
      @(posedge i_clk)
      begin
         if (w == 0) i_tx_wr <= v;
         if (w == 1) i_rx_rd <= v;
         if (w == 2) i_err_clr <= v;
         if (w == 3) i_vec_wr <= v[0];
         if (w == 4) i_int_ack <= v[0];
         if (w == 5) go <= v[0];
      end
      @(posedge i_clk) {i_tx_wr, i_rx_rd, i_err_clr, i_vec_wr, i_int_ack, go} <= 9'h000;
   endtask : strobe
   task wait_on(input logic sel, input int b, input logic lvl);
      int k;
      for (k = 0; k < 3000 && (sel ? o_txd[b] : o_status[b]) !== lvl; k++)
         @(negedge i_clk);
      check(k < 3000, 16'h1);
   endtask : wait_on
   task send(input logic [7:0] c, input logic [3:0] n, input logic s);
      @(posedge i_clk) {pc, nb, bad} <= {c, n, s};
      strobe(5, 2'h1);
   endtask : send
   // ****************
   // scenarios
   // ****************
   task t_receive;
      send(8'hA5, 4'h8, 1'b0);
      wait_on(1'b0, 0, 1'b1);
      check(o_rx_data[7:0], 8'hA5);
      check(o_status[6], 1'b0);
      strobe(1, 2'h1);
      step(2);
      check(o_status[0], 1'b0);
      @(posedge i_clk) i_rx_len <= 4'hC;
      send(8'hF3, 4'h5, 1'b0);
      wait_on(1'b0, 0, 1'b1);
      check(o_rx_data[7:0] & 8'h1F, 8'h13);
      strobe(1, 2'h1);
      send(8'h0C, 4'h5, 1'b1);
      wait_on(1'b0, 6, 1'b1);
      send(8'h0A, 4'h5, 1'b0);
      wait_on(1'b0, 5, 1'b1);
      strobe(2, 2'h1);
      step(2);
      check(o_status[6], 1'b0);
      check(o_status[5], 1'b0);
      strobe(1, 2'h1);
      @(posedge i_clk) i_rx_len <= 4'hF;
   endtask : t_receive
   task t_loop(input logic [1:0] s);
      realtime t0;
      @(posedge i_clk) {i_par_en, i_par_odd, i_stop_sel, i_tx_data} <= {4'hF, 2'h0, s, 16'h005C};
      strobe(0, 2'h1);
      wait_on(1'b1, 0, 1'b0);
      t0 = $realtime;
      wait_on(1'b0, 2, 1'b1);
      @(posedge i_clk) i_tx_data <= 16'h00C3;
      strobe(0, 2'h1);
      wait_on(1'b0, 8, 1'b1);
      check(o_rx_data[15:8], 8'h5C);
      check(o_status[12], 1'b0);
      strobe(1, 2'h2);
      wait_on(1'b1, 0, 1'b1);
      wait_on(1'b1, 0, 1'b0);
      check(int'(($realtime - t0) / 100.0) - 320 - 32 - 16 * int'(s) inside {[-2:2]}, 16'h1);
      wait_on(1'b0, 8, 1'b1);
      check(o_rx_data[15:8], 8'hC3);
      strobe(1, 2'h2);
      @(posedge i_clk) i_par_en <= 2'h0;
   endtask : t_loop
   task t_irq;
      @(posedge i_clk) {i_mode, i_vec_data} <= {4'h1, 8'hA8};
      strobe(3, 2'h1);
      step(3);
      check(o_int_req, 1'b1);
      strobe(4, 2'h1);
      step(1);
      check(o_vector, 8'hA8);
      @(posedge i_clk) i_mode <= 4'h4;
      step(3);
      strobe(4, 2'h1);
      step(1);
      check(o_vector, 8'hA9);
      @(posedge i_clk) i_mode <= 4'h0;
      step(3);
      check(o_int_req, 1'b0);
   endtask : t_irq
   task t_block;
      @(posedge i_clk) i_mode <= 4'h2;
      send(8'h81, 4'h8, 1'b0);
      wait_on(1'b0, 0, 1'b1);
      step(1);
      check({o_int_req, o_ready[0]}, 2'h3);
      strobe(1, 2'h1);
      send(8'h42, 4'h8, 1'b0);
      wait_on(1'b0, 0, 1'b1);
      step(1);
      check({o_int_req, o_ready[0]}, 2'h1);
      strobe(1, 2'h1);
      step(2);
      check(o_ready[0], 1'b0);
   endtask : t_block
   task print_verdict;
      if (bad_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   initial
   begin
      #3000000;
      bad_count++;
      print_verdict();
   end
   initial
   begin
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      step(2);
      check(o_status, 16'h0404);
      check({o_txd, o_vector}, 10'h300);
      t_receive();
      for (int s = 0; s < 3; s++)
         t_loop(s[1:0]);
      t_irq();
      t_block();
      print_verdict();
   end
endmodule : testbench
